// file: include/sswd_cfg.svh
`ifndef SSWD_CFG_SVH
`define SSWD_CFG_SVH

// System clock
`define SSWD_MCLK_PERIOD_NS 10
// Internal oscillator tick, one per millisecond
`define SSWD_TICK_PERIOD_NS 1000000
`define SSWD_OSC_DIV (`SSWD_TICK_PERIOD_NS / `SSWD_MCLK_PERIOD_NS)
`define SSWD_OSC_CNT_W 17

// Internal oscillator timing, in milliseconds
`define SSWD_RST_STRETCH_MS 200
`define SSWD_WDT_LONG_MS 1600
`define SSWD_WDT_SHORT_MS 100
`define SSWD_MS_NS 1000000
`define SSWD_RST_STRETCH_TICKS (`SSWD_RST_STRETCH_MS * `SSWD_MS_NS / `SSWD_TICK_PERIOD_NS)
`define SSWD_WDT_LONG_TICKS (`SSWD_WDT_LONG_MS * `SSWD_MS_NS / `SSWD_TICK_PERIOD_NS)
`define SSWD_WDT_SHORT_TICKS (`SSWD_WDT_SHORT_MS * `SSWD_MS_NS / `SSWD_TICK_PERIOD_NS)

// External timebase: prescale and fixed tick counts
`define SSWD_EXT_PRESCALE 64
`define SSWD_EXT_PRE_W 6
`define SSWD_EXT_STRETCH_TICKS 16
`define SSWD_EXT_WDT_TICKS 64

// Timer counter width
`define SSWD_CNT_W 11

// Synchronised pin vector positions
`define SSWD_PIN_N 8
`define SSWD_PIN_SUPPLY 0
`define SSWD_PIN_SWITCH 1
`define SSWD_PIN_FAIL 2
`define SSWD_PIN_KICK_LVL 3
`define SSWD_PIN_KICK_FLT 4
`define SSWD_PIN_CE 5
`define SSWD_PIN_TB_SEL 6
`define SSWD_PIN_TB_IN 7
// Synchroniser reset: supply bad, kick floating, chip select idle, internal timebase
`define SSWD_PIN_RST 8'h71

`endif

// file: include/sswd_pkg.sv
package sswd_pkg;

  // Supervisor operating mode
  typedef enum logic [1:0] {
    SSWD_HOLD    = 2'b00,
    SSWD_STRETCH = 2'b01,
    SSWD_RUN     = 2'b10,
    SSWD_BACKUP  = 2'b11
  } sswd_mode_t;

  // Resolved three-level kick input
  typedef enum logic [1:0] {
    SSWD_KICK_LOW   = 2'b00,
    SSWD_KICK_HIGH  = 2'b01,
    SSWD_KICK_FLOAT = 2'b10
  } sswd_kick_t;

endpackage

// file: hdl/sswd_timer.sv
`include "sswd_cfg.svh"

// Down counter stepped by the timebase tick
module sswd_timer (
  input  wire logic                   mclk,
  input  wire logic                   rst,
  input  wire logic                   load,
  input  wire logic [`SSWD_CNT_W-1:0] load_val,
  input  wire logic                   tick,
  output logic                        expired
);

  logic [`SSWD_CNT_W-1:0] count;
  logic [`SSWD_CNT_W-1:0] next_count;

  // Load wins over a tick, so a reload never loses a step to the old period
  assign next_count = load ? load_val :
                      (tick && count != '0) ? count - `SSWD_CNT_W'(1) : count;

  // Expired while the count rests at zero and no reload is pending
  assign expired = (count == '0) && !load;

  // Counter register
  always_ff @(posedge mclk) begin
    if (rst) begin
      count <= '0;
    end else begin
      count <= next_count;
    end
  end

endmodule

// file: hdl/sswd_top.sv
`include "sswd_cfg.svh"

// Overview of operation
// - Reset low on low supply or battery.
// - Hold reset at least 140 ms after recovery.
// - Unkicked watchdog pulses reset each timeout.
// - Active-high reset is complement of reset.
// - Supply-low flag follows comparator, low on battery, no stretching.
// - Floating kick input disables the watchdog.
// - Every kick edge restarts the watchdog.
// - Timeout drives reset and expired low.
// - Expired clears on kick edge or supply-low.
// - Chip select gated high on low supply.
// - Select high uses internal oscillator timing.
// - Select low counts external timebase cycles.
// - Internal reset stretch is 200 ms.
// - Timebase level picks 1.6 s or 100 ms.
// - First timeout after reset is 1600 ticks (1.6 s on the internal oscillator).
// - Backup output high while on battery.
// - Fail warning follows comparator, low on battery.
// - External clock divided by 64 first.
// - Backup mode ignores inputs, holds outputs.
module sswd_top #(
  parameter int OSC_DIV = `SSWD_OSC_DIV
) (
  input  wire logic mclk,
  input  wire logic rst,
  input  wire logic supply_comparator,
  input  wire logic switchover_comparator,
  input  wire logic fail_comparator,
  input  wire logic watchdog_kick_in,
  input  wire logic watchdog_kick_float,
  input  wire logic chip_select_in_n,
  input  wire logic timebase_select,
  input  wire logic timebase_input,
  output logic      reset_n,
  output logic      reset,
  output logic      supply_low_n,
  output logic      watchdog_expired_n,
  output logic      chip_select_out_n,
  output logic      backup_active,
  output logic      fail_warn_n
);

  // Timeout length for the current timebase and kick history
  function automatic logic [`SSWD_CNT_W-1:0] wdt_period(
    input logic internal,
    input logic level_long,
    input logic force_long
  );
    logic [`SSWD_CNT_W-1:0] val;
    val = `SSWD_CNT_W'(`SSWD_WDT_LONG_TICKS);
    if (!force_long) begin
      if (!internal) begin
        val = `SSWD_CNT_W'(`SSWD_EXT_WDT_TICKS);
      end else if (!level_long) begin
        val = `SSWD_CNT_W'(`SSWD_WDT_SHORT_TICKS);
      end
    end
    return val;
  endfunction

  // Pin synchroniser stages
  logic [`SSWD_PIN_N-1:0] pin_meta;
  logic [`SSWD_PIN_N-1:0] pin_sync;
  logic [`SSWD_PIN_N-1:0] pin_raw;

  assign pin_raw = {timebase_input, timebase_select, chip_select_in_n,
                    watchdog_kick_float, watchdog_kick_in, fail_comparator,
                    switchover_comparator, supply_comparator};

  // Two flops on every pin; only the second stage is read by logic
  always_ff @(posedge mclk) begin
    if (rst) begin
      pin_meta <= `SSWD_PIN_RST; // Safe levels until real pins arrive
      pin_sync <= `SSWD_PIN_RST;
    end else begin
      pin_meta <= pin_raw;
      pin_sync <= pin_meta;
    end
  end

  // Named views of the synchronised pins
  logic supply_bad;
  logic on_battery;
  logic fail_ok;
  logic ce_in_s;
  logic tb_internal;
  logic tb_level;
  logic supply_good;

  assign supply_bad  = pin_sync[`SSWD_PIN_SUPPLY];
  assign on_battery  = pin_sync[`SSWD_PIN_SWITCH];
  assign fail_ok     = pin_sync[`SSWD_PIN_FAIL];
  assign ce_in_s     = pin_sync[`SSWD_PIN_CE];
  assign tb_internal = pin_sync[`SSWD_PIN_TB_SEL];
  assign tb_level    = pin_sync[`SSWD_PIN_TB_IN];
  assign supply_good = !supply_bad && !on_battery;

  // Internal oscillator stand-in: one tick per millisecond
  logic [`SSWD_OSC_CNT_W-1:0] osc_cnt;
  logic                       osc_wrap;

  assign osc_wrap = (osc_cnt == `SSWD_OSC_CNT_W'(OSC_DIV - 1));

  always_ff @(posedge mclk) begin
    if (rst || osc_wrap) begin
      osc_cnt <= '0;
    end else begin
      osc_cnt <= osc_cnt + `SSWD_OSC_CNT_W'(1);
    end
  end

  // External timebase: rising edges counted and divided by 64
  logic                       tb_prev;
  logic [`SSWD_EXT_PRE_W-1:0] ext_pre;
  logic                       tb_rise;
  logic                       ext_wrap;

  assign tb_rise  = tb_level && !tb_prev;
  assign ext_wrap = tb_rise && (ext_pre == `SSWD_EXT_PRE_W'(`SSWD_EXT_PRESCALE - 1));

  // Prescaler wraps naturally at its width, which equals the divide ratio
  always_ff @(posedge mclk) begin
    if (rst) begin
      tb_prev <= 1'b0;
      ext_pre <= '0;
    end else begin
      tb_prev <= tb_level;
      if (tb_rise) begin
        ext_pre <= ext_pre + `SSWD_EXT_PRE_W'(1);
      end
    end
  end

  // Timer tick source chosen by the select pin
  logic tick;

  assign tick = tb_internal ? osc_wrap : ext_wrap;

  // Kick input resolved to three levels
  sswd_pkg::sswd_kick_t kick_now;
  sswd_pkg::sswd_kick_t kick_prev;
  logic                 kick_float;
  logic                 kick_edge;

  assign kick_now   = pin_sync[`SSWD_PIN_KICK_FLT] ? sswd_pkg::SSWD_KICK_FLOAT :
                      pin_sync[`SSWD_PIN_KICK_LVL] ? sswd_pkg::SSWD_KICK_HIGH :
                                                     sswd_pkg::SSWD_KICK_LOW;
  assign kick_float = (kick_now == sswd_pkg::SSWD_KICK_FLOAT);
  // Only a driven-to-driven change counts; floating is never an edge source
  assign kick_edge  = !kick_float && (kick_prev != sswd_pkg::SSWD_KICK_FLOAT) &&
                      (kick_now != kick_prev);

  always_ff @(posedge mclk) begin
    if (rst) begin
      kick_prev <= sswd_pkg::SSWD_KICK_FLOAT;
    end else begin
      kick_prev <= kick_now;
    end
  end

  // Mode register and timers
  sswd_pkg::sswd_mode_t mode;
  sswd_pkg::sswd_mode_t next_mode;
  logic                 force_long;
  logic                 next_force_long;
  logic                 stretch_done;
  logic                 wdt_done;
  logic                 wdt_fire;
  logic                 stretch_load;
  logic                 wdt_load;
  logic [`SSWD_CNT_W-1:0] stretch_val;
  logic [`SSWD_CNT_W-1:0] wdt_val;

  // Stretch length fixed per timebase mode
  assign stretch_val  = tb_internal ? `SSWD_CNT_W'(`SSWD_RST_STRETCH_TICKS) :
                                      `SSWD_CNT_W'(`SSWD_EXT_STRETCH_TICKS);
  assign stretch_load = (mode != sswd_pkg::SSWD_STRETCH);
  assign wdt_val      = wdt_period(tb_internal, tb_level, force_long);
  // Watchdog held at its start while disabled, outside run, or kicked
  assign wdt_load     = (mode != sswd_pkg::SSWD_RUN) || kick_float || kick_edge;
  assign wdt_fire     = wdt_done && (mode == sswd_pkg::SSWD_RUN);

  sswd_timer u_stretch (
    .mclk     (mclk),
    .rst      (rst),
    .load     (stretch_load),
    .load_val (stretch_val),
    .tick     (tick),
    .expired  (stretch_done)
  );

  sswd_timer u_wdt (
    .mclk     (mclk),
    .rst      (rst),
    .load     (wdt_load),
    .load_val (wdt_val),
    .tick     (tick),
    .expired  (wdt_done)
  );

  // Mode sequencing; battery and supply loss override everything
  always_comb begin
    next_mode = mode;
    unique case (mode)
      sswd_pkg::SSWD_HOLD: begin
        if (!supply_bad) begin
          next_mode = sswd_pkg::SSWD_STRETCH;
        end
      end
      sswd_pkg::SSWD_STRETCH: begin
        if (stretch_done) begin
          next_mode = sswd_pkg::SSWD_RUN;
        end
      end
      sswd_pkg::SSWD_RUN: begin
        if (wdt_fire) begin
          next_mode = sswd_pkg::SSWD_STRETCH;
        end
      end
      sswd_pkg::SSWD_BACKUP: begin
        next_mode = sswd_pkg::SSWD_HOLD;
      end
    endcase
    if (supply_bad) begin
      next_mode = sswd_pkg::SSWD_HOLD;
    end
    if (on_battery) begin
      next_mode = sswd_pkg::SSWD_BACKUP;
    end
  end

  // Long period armed by any reset, dropped after the first kick or timeout
  assign next_force_long = (mode != sswd_pkg::SSWD_RUN) ? 1'b1 :
                           (kick_edge || wdt_fire) ? 1'b0 : force_long;

  always_ff @(posedge mclk) begin
    if (rst) begin
      mode       <= sswd_pkg::SSWD_HOLD;
      force_long <= 1'b1;
    end else begin
      mode       <= next_mode;
      force_long <= next_force_long;
    end
  end

  // Output next values, all decoded from synchronised state
  logic next_reset_n;
  logic next_supply_low_n;
  logic next_wdo_n;
  logic next_ce_n;
  logic next_fail_n;
  logic supply_low_fall;

  assign next_reset_n      = (next_mode == sswd_pkg::SSWD_RUN);
  assign next_supply_low_n = supply_good;
  assign supply_low_fall   = supply_low_n && !next_supply_low_n;
  // Clearing events win over a timeout seen in the same cycle
  assign next_wdo_n        = (on_battery || kick_edge || supply_low_fall) ? 1'b1 :
                             wdt_fire ? 1'b0 : watchdog_expired_n;
  // Gating adds the synchroniser delay; acceptable against slow supply ramps
  assign next_ce_n         = supply_good ? ce_in_s : 1'b1;
  assign next_fail_n       = fail_ok && !on_battery;

  // Output registers
  always_ff @(posedge mclk) begin
    if (rst) begin
      reset_n            <= 1'b0;
      reset              <= 1'b1;
      supply_low_n       <= 1'b0;
      watchdog_expired_n <= 1'b1;
      chip_select_out_n  <= 1'b1;
      backup_active      <= 1'b0;
      fail_warn_n        <= 1'b0;
    end else begin
      reset_n            <= next_reset_n;
      reset              <= !next_reset_n;
      supply_low_n       <= next_supply_low_n;
      watchdog_expired_n <= next_wdo_n;
      chip_select_out_n  <= next_ce_n;
      backup_active      <= on_battery;
      fail_warn_n        <= next_fail_n;
    end
  end

  // Checks on the supervisor behaviour
  property p_supply_reset;
    @(posedge mclk) disable iff (rst)
    (supply_bad || on_battery) |=> !reset_n;
  endproperty
  a_supply_reset: assert property (p_supply_reset)
    else $error("reset not asserted on low supply");

  property p_release_after_stretch;
    @(posedge mclk) disable iff (rst)
    $rose(reset_n) |-> $past(stretch_done) && $past(mode) == sswd_pkg::SSWD_STRETCH;
  endproperty
  a_release_after_stretch: assert property (p_release_after_stretch)
    else $error("reset released without full stretch");

  property p_reset_compl;
    @(posedge mclk) disable iff (rst)
    reset == !reset_n;
  endproperty
  a_reset_compl: assert property (p_reset_compl)
    else $error("reset outputs not complementary");

  property p_low_flag;
    @(posedge mclk) disable iff (rst)
    1'b1 |=> supply_low_n == $past(!supply_bad && !on_battery);
  endproperty
  a_low_flag: assert property (p_low_flag)
    else $error("supply-low flag wrong");

  property p_float_disables;
    @(posedge mclk) disable iff (rst)
    kick_float |=> !$fell(watchdog_expired_n);
  endproperty
  a_float_disables: assert property (p_float_disables)
    else $error("floating kick let watchdog expire");

  property p_timeout;
    @(posedge mclk) disable iff (rst)
    wdt_fire && !on_battery && !supply_bad && !supply_low_fall |=>
      !watchdog_expired_n && !reset_n && reset;
  endproperty
  a_timeout: assert property (p_timeout)
    else $error("timeout did not drive reset and expired low");

  property p_kick_clears;
    @(posedge mclk) disable iff (rst)
    kick_edge |=> watchdog_expired_n;
  endproperty
  a_kick_clears: assert property (p_kick_clears)
    else $error("kick edge did not clear expired");

  property p_ce_gate;
    @(posedge mclk) disable iff (rst)
    1'b1 |=> chip_select_out_n == ($past(supply_good) ? $past(ce_in_s) : 1'b1);
  endproperty
  a_ce_gate: assert property (p_ce_gate)
    else $error("chip select gating wrong");

  property p_long_after_reset;
    @(posedge mclk) disable iff (rst)
    (mode == sswd_pkg::SSWD_STRETCH) && (next_mode == sswd_pkg::SSWD_RUN) |->
      wdt_val == `SSWD_CNT_W'(`SSWD_WDT_LONG_TICKS);
  endproperty
  a_long_after_reset: assert property (p_long_after_reset)
    else $error("first timeout after reset not long");

  property p_fail_warn;
    @(posedge mclk) disable iff (rst)
    1'b1 |=> fail_warn_n == ($past(fail_ok) && !$past(on_battery)) &&
             backup_active == $past(on_battery);
  endproperty
  a_fail_warn: assert property (p_fail_warn)
    else $error("fail warning or backup output wrong");

  property p_backup_hold;
    @(posedge mclk) disable iff (rst)
    on_battery |=> !reset_n && watchdog_expired_n && chip_select_out_n;
  endproperty
  a_backup_hold: assert property (p_backup_hold)
    else $error("backup mode outputs wrong");

endmodule

// file: bench/sswd_host_model.sv
// Processor and RAM side: kicks the watchdog and drives the RAM chip select
module sswd_host_model #(
  parameter int GAP = 40
) (
  input  wire logic       mclk,
  input  wire logic       reset_n,
  input  wire logic [1:0] kick_mode,
  input  wire logic       cs_rand,
  output logic            kick_level,
  output logic            kick_float,
  output logic            cs_n
);
  timeunit 1ns;
  timeprecision 1ps;

  int gap_cnt;

  initial begin
    kick_level = 1'b0;
    kick_float = 1'b0;
    cs_n       = 1'b1;
    gap_cnt    = 0;
  end

  // Mode 0 holds, 1 toggles every GAP cycles, 2 releases the pin
  always @(negedge mclk) begin
    kick_float <= (kick_mode == 2'd2);
    if (kick_mode == 2'd2) begin
      kick_level <= ~kick_level; // Released line shows a changing pattern
      gap_cnt    <= 0;
    end else if (kick_mode == 2'd1 && reset_n) begin
      gap_cnt <= gap_cnt + 1;
      if (gap_cnt >= GAP - 1) begin
        gap_cnt    <= 0;
        kick_level <= ~kick_level;
      end
    end else begin
      gap_cnt <= 0; // A processor held in reset does not kick
    end
    cs_n <= cs_rand ? 1'($urandom) : 1'b1;
  end
endmodule

// file: bench/supply_supervisor_watchdog_tb_top.sv
module supply_supervisor_watchdog_tb_top;
  timeunit 1ns;
  timeprecision 1ps;

  localparam int D = 10;

  logic       mclk, rst, sup, sw, fail, tb_sel, tb_in, ext_run, rnd_on, cs_rand, ph;
  logic [1:0] kick_mode;
  logic       kick_level, kick_float, cs_n;
  logic       reset_n, reset, supply_low_n, expired_n, cs_out_n, backup_active, fail_warn_n;
  int         error_cnt, n_checks, n;
  logic [3:0] hist[$];

  sswd_top #(.OSC_DIV(D)) dut_u (
    .mclk                  (mclk),
    .rst                   (rst),
    .supply_comparator     (sup),
    .switchover_comparator (sw),
    .fail_comparator       (fail),
    .watchdog_kick_in      (kick_level),
    .watchdog_kick_float   (kick_float),
    .chip_select_in_n      (cs_n),
    .timebase_select       (tb_sel),
    .timebase_input        (tb_in),
    .reset_n               (reset_n),
    .reset                 (reset),
    .supply_low_n          (supply_low_n),
    .watchdog_expired_n    (expired_n),
    .chip_select_out_n     (cs_out_n),
    .backup_active         (backup_active),
    .fail_warn_n           (fail_warn_n)
  );

  sswd_host_model #(.GAP(40)) host_u (
    .mclk       (mclk),
    .reset_n    (reset_n),
    .kick_mode  (kick_mode),
    .cs_rand    (cs_rand),
    .kick_level (kick_level),
    .kick_float (kick_float),
    .cs_n       (cs_n)
  );

  always #5 mclk = ~mclk;

  task check(input logic seen, input logic exp);
    n_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task rng(input int v, input int lo, input int hi);
    check(v >= lo && v <= hi, 1'b1);
  endtask

  task complete_run;
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // Count falling edges until reset_n (0) or expired (1) reaches lvl
  task measure(input int which, input logic lvl, input int lim, output int cnt);
    cnt = 0;
    while (cnt < lim && (which == 0 ? reset_n : expired_n) !== lvl) begin
      @(negedge mclk);
      cnt++;
    end
  endtask

  // Pin history: levels pass two sync flops and an output flop
  always @(posedge mclk) begin
    if (rst) begin
      hist.delete();
    end else begin
      hist.push_back({sup, sw, fail, cs_n});
      if (hist.size() > 3) void'(hist.pop_front());
    end
  end

  // Reference model of the level outputs, checked every cycle
  always @(negedge mclk) begin
    if (!rst && hist.size() == 3) begin
      check(reset, ~reset_n);
      check(backup_active, hist[0][2]);
      check(fail_warn_n, hist[0][1] & ~hist[0][2]);
      check(supply_low_n, ~(hist[0][3] | hist[0][2]));
      check(cs_out_n, hist[0][3] | hist[0][2] | hist[0][0]);
      if (hist[0][3] | hist[0][2]) check(reset_n, 1'b0);
      if (hist[0][2]) check(expired_n, 1'b1);
    end
  end

  // Random fail sense; external timebase toggles every two cycles
  always @(negedge mclk) begin
    if (rnd_on) fail <= 1'($urandom);
    if (ext_run) begin
      ph <= ~ph;
      if (ph) tb_in <= ~tb_in;
    end
  end

  initial begin
    #1000000;
    error_cnt++;
    complete_run();
  end

  initial begin
    mclk = 0; rst = 1; sup = 0; sw = 0; fail = 1; tb_sel = 1; tb_in = 0; ph = 0;
    ext_run = 0; rnd_on = 0; cs_rand = 1; kick_mode = 2'd0; error_cnt = 0; n_checks = 0;
    void'($urandom(32'h2cc2d0ab));
    repeat (10) @(negedge mclk);
    rst <= 0;
    rnd_on <= 1;
    measure(0, 1'b1, 300 * D, n);
    rng(n, 200 * D, 201 * D + 8);
    $display("test power_up done");
    // Kicked watchdog stays quiet, then a held kick times out short
    kick_mode <= 2'd1;
    repeat (3000) @(negedge mclk);
    check(expired_n, 1'b1);
    kick_mode <= 2'd0;
    measure(1, 1'b0, 200 * D, n);
    rng(n, 100 * D - 50, 101 * D + 8);
    check(reset_n, 1'b0);
    measure(0, 1'b1, 300 * D, n);
    rng(n, 200 * D, 201 * D + 8);
    measure(0, 1'b0, 1700 * D, n);
    rng(n, 1599 * D, 1601 * D + 8);
    kick_mode <= 2'd1;
    measure(1, 1'b1, 300 * D, n);
    rng(n, 200 * D, 201 * D + 50);
    // Timebase level high selects the long timeout once kicks stop
    tb_in <= 1;
    repeat (200) @(negedge mclk);
    kick_mode <= 2'd0;
    measure(1, 1'b0, 1700 * D, n);
    rng(n, 1599 * D - 50, 1601 * D + 8);
    tb_in <= 0;
    kick_mode <= 2'd1;
    measure(1, 1'b1, 300 * D, n);
    rng(n, 200 * D, 201 * D + 50);
    $display("test watchdog done");
    // Released kick pin disables the timeout
    repeat (200) @(negedge mclk);
    kick_mode <= 2'd2;
    measure(0, 1'b0, 300 * D, n);
    check(n == 300 * D, 1'b1);
    check(expired_n, 1'b1);
    kick_mode <= 2'd0;
    measure(1, 1'b0, 200 * D, n);
    rng(n, 100 * D - 5, 101 * D + 8);
    $display("test float done");
    // Supply dip clears expired and restarts the stretch
    sup <= 1;
    repeat (4) @(negedge mclk);
    check(expired_n, 1'b1);
    repeat (20) @(negedge mclk);
    sup <= 0;
    measure(0, 1'b1, 300 * D, n);
    rng(n, 199 * D + 5, 201 * D + 8);
    $display("test supply done");
    // Backup ignores kick, select and timebase
    kick_mode <= 2'd2;
    sw <= 1;
    repeat (200) begin
      tb_sel <= 1'($urandom);
      tb_in <= 1'($urandom);
      @(negedge mclk);
    end
    sw <= 0;
    tb_sel <= 1;
    tb_in <= 0;
    measure(0, 1'b1, 300 * D, n);
    rng(n, 199 * D + 5, 201 * D + 20);
    $display("test backup done");
    // External timebase: 16 ticks of 64 input edges each
    tb_sel <= 0;
    ext_run <= 1;
    repeat (20) @(negedge mclk);
    sup <= 1;
    repeat (10) @(negedge mclk);
    sup <= 0;
    measure(0, 1'b1, 8000, n);
    rng(n, 15 * 256, 17 * 256 + 20);
    // External timeout: kicks drop the long period, then 64 ticks
    kick_mode <= 2'd1;
    repeat (200) @(negedge mclk);
    kick_mode <= 2'd0;
    measure(1, 1'b0, 70 * 256, n);
    rng(n, 63 * 256 - 50, 64 * 256 + 20);
    ext_run <= 0;
    $display("test external done");
    complete_run();
  end
endmodule
